// [hub_axil_regs.sv]
// AXI4-Lite slave giving access to the controller's own registers
// assumes one outstanding write and one read; reads answer the cycle after the handshake, writes one cycle later
`timescale 1ns/10ps
module hub_axil_regs
  import hub_pm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register access
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok,
  input wire logic wr_ok
);
  logic aw_held, w_held;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0] aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q;
  logic [3:0] s_q, next_s_q;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign arready = ~rvalid;
  assign rd_addr = araddr;
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_q = aw_q;
    next_w_q = w_q;
    next_s_q = s_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    wr_stb = 1'b0;
    wr_addr = aw_q;
    wr_data = w_q;
    wr_strb = s_q;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_q = wdata;
      next_s_q = wstrb;
    end
    if (aw_held && w_held) begin
      wr_stb = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_ok ? rd_data : 32'h0000_0000;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      s_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h0000_0000;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_q <= next_aw_q;
      w_q <= next_w_q;
      s_q <= next_s_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end
  chk_b_after_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_stb |=> bvalid)
    else $error("write response missing");
endmodule

// [hub_dev_model.sv]
// behavioural model of the hub device and its external power switches
// assumes pins synchronous to aclk; the bench commands bus idle and wakeup events
`timescale 1ns/10ps
module hub_dev_model #(
  parameter int IDLE_CYC = 40
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // upstream and downstream events
  input wire logic bus_active,
  input wire logic host_k,
  input wire logic dn_event,
  input wire logic ext_irq_one,
  input wire logic fault2,
  input wire logic fault3,
  // controller side
  input wire logic sleep_exec,
  input wire logic flag_clear,
  output logic global_suspend_flag,
  output logic resume_flag,
  output logic function_wakeup_flag,
  output logic osc_on,
  output logic dn_signalling,
  output logic gpio_d_bit0,
  output logic gpio_d_bit1,
  // selective port command from the controller
  input wire logic [2:0] port_command_field,
  input wire logic [2:0] port_address_field,
  input wire logic port_cmd_stb,
  // port state seen by the bench
  output logic [5:0] last_port_cmd,
  output logic port_susp_chg
);
  int idle_cnt;
  logic wake;
  // events outside suspend are dropped, not queued for later
  assign wake = global_suspend_flag && (host_k || dn_event || ext_irq_one);
  assign dn_signalling = !global_suspend_flag;
  // switch fault outputs pulled up, low while faulted
  assign gpio_d_bit0 = !fault2;
  assign gpio_d_bit1 = !fault3;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt <= 0;
      global_suspend_flag <= 1'b0;
      resume_flag <= 1'b0;
      function_wakeup_flag <= 1'b0;
      osc_on <= 1'b1;
      last_port_cmd <= 6'h00;
      port_susp_chg <= 1'b0;
    end else begin
      idle_cnt <= (bus_active || global_suspend_flag) ? 0 : idle_cnt + 1;
      if (!bus_active && idle_cnt == IDLE_CYC - 1) global_suspend_flag <= 1'b1;
      // no IN traffic here, so a new suspend drops the unreported change
      if (!bus_active && idle_cnt == IDLE_CYC - 1) port_susp_chg <= 1'b0;
      if (port_cmd_stb) last_port_cmd <= {port_address_field, port_command_field};
      if (global_suspend_flag && sleep_exec) osc_on <= 1'b0;
      if (wake) begin
        resume_flag <= 1'b1;
        osc_on <= 1'b1;
      end
      if (wake && ext_irq_one) function_wakeup_flag <= 1'b1;
      if (flag_clear) begin
        // change stands until the next suspend entry drops it
        port_susp_chg <= resume_flag;
        resume_flag <= 1'b0;
        global_suspend_flag <= 1'b0;
        function_wakeup_flag <= 1'b0;
      end
    end
  end
endmodule

// [hub_fall_detect.sv]
// falling-edge detector for a fault sense pin
// assumes the pin is synchronous to aclk
`timescale 1ns/10ps
module hub_fall_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin and event
  input wire logic pin,
  output logic fell
);
  logic last;
  logic next_last;
  always_comb begin
    next_last = pin;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last <= 1'b1;
    end else begin
      last <= next_last;
    end
  end
  assign fell = last & ~pin;
endmodule

// [hub_pm_ctrl.sv]
// firmware-side controller for hub suspend, resume and port power
// assumes the hub device pins are synchronous to aclk; software uses AXI4-Lite
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module hub_pm_ctrl
  import hub_pm_pkg::*;
#(
  parameter int RESUME_WAIT = RESUME_WAIT_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // hub flags seen by firmware
  input wire logic global_suspend_flag,
  input wire logic resume_flag,
  input wire logic function_wakeup_flag,
  output logic flag_clear,
  // cpu sleep control
  output logic sleep_enable_bit,
  output logic [1:0] sleep_mode_bits,
  output logic sleep_exec,
  output logic [7:0] suspend_overcurrent_enable,
  // fault sense and power switches
  input wire logic gpio_d_bit0,
  input wire logic gpio_d_bit1,
  output logic gang_power_n,
  output logic second_port_power_n,
  output logic third_port_power_n,
  // selective suspend command
  output logic [2:0] port_command_field,
  output logic [2:0] port_address_field,
  output logic port_cmd_stb,
  // embedded function endpoints
  output logic fn_endpoints_en
);
  logic wr_stb, rd_ok, wr_ok;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic fall0, fall1;
  logic [31:0] ctrl, next_ctrl;
  logic [1:0] pwr_bits, next_pwr_bits;
  logic hub_oc, hub_oc_chg, oc2, oc3;
  logic next_hub_oc, next_hub_oc_chg, next_oc2, next_oc3;
  logic fn_susp, fn_en, fn_chg, next_fn_susp, next_fn_en, next_fn_chg;
  logic [31:0] wait_cnt, next_wait_cnt;
  logic [2:0] next_cmd, next_addr;
  logic next_cmd_stb;
  pm_state_t state, next_state;

  hub_axil_regs u_regs (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok), .wr_ok(wr_ok)
  );
  hub_fall_detect u_fall0 (.aclk(aclk), .aresetn(aresetn), .pin(gpio_d_bit0),
    .fell(fall0));
  hub_fall_detect u_fall1 (.aclk(aclk), .aresetn(aresetn), .pin(gpio_d_bit1),
    .fell(fall1));

  // register reads
  always_comb begin
    rd_ok = 1'b1;
    unique case (rd_addr)
      OFS_CTRL: rd_data = ctrl;
      OFS_STATUS: rd_data = {24'h00_0000, fn_chg, fn_en, fn_susp, oc3, oc2,
        hub_oc_chg, hub_oc, state == S_SLEEP};
      OFS_PORTCMD: rd_data = {26'h000_0000, port_address_field, port_command_field};
      OFS_PWR: rd_data = {30'h0000_0000, pwr_bits};
      default: begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
    wr_ok = (wr_addr == OFS_CTRL) || (wr_addr == OFS_STATUS) ||
      (wr_addr == OFS_PORTCMD) || (wr_addr == OFS_PWR);
  end

  // sleep / wake sequencing and protection
  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_pwr_bits = pwr_bits;
    next_hub_oc = hub_oc;
    next_hub_oc_chg = hub_oc_chg;
    next_oc2 = oc2;
    next_oc3 = oc3;
    next_fn_susp = fn_susp;
    next_fn_en = fn_en;
    next_fn_chg = fn_chg;
    next_wait_cnt = wait_cnt;
    next_cmd = port_command_field;
    next_addr = port_address_field;
    next_cmd_stb = 1'b0;
    // software writes; status write-one clears, hardware set below wins
    if (wr_stb && wr_strb[0]) begin
      unique case (wr_addr)
        OFS_CTRL: next_ctrl = wr_data;
        OFS_STATUS: begin
          next_hub_oc_chg = hub_oc_chg & ~wr_data[ST_HUB_OC_CHG];
          next_hub_oc = hub_oc & ~wr_data[ST_HUB_OC];
          next_oc2 = oc2 & ~wr_data[ST_OC2];
          next_oc3 = oc3 & ~wr_data[ST_OC3];
          next_fn_chg = fn_chg & ~wr_data[ST_FN_SUSP_CHG];
        end
        OFS_PORTCMD: begin
          next_cmd = wr_data[2:0];
          next_addr = wr_data[5:3];
          next_cmd_stb = 1'b1;
        end
        OFS_PWR: next_pwr_bits = wr_data[1:0];
        default: next_ctrl = ctrl;
      endcase
    end
    unique case (state)
      S_RUN: if (global_suspend_flag && ctrl[CTRL_SLEEP_REQ]) begin
        next_state = S_SLEEP;
      end
      S_SLEEP: if (resume_flag) begin
        next_state = S_WAKE;
      end
      S_WAKE: begin
        next_state = S_RUN;
        next_ctrl[CTRL_SLEEP_REQ] = 1'b0;
      end
    endcase
    // overcurrent: fault pins active low
    if (ctrl[CTRL_GLOBAL_MODE]) begin
      if (fall0) begin
        next_hub_oc = 1'b1;
        next_hub_oc_chg = 1'b1;
        next_pwr_bits = 2'b00;
      end
    end else begin
      if (fall0) begin
        next_oc2 = 1'b1;
        next_pwr_bits[0] = 1'b0;
      end
      if (fall1) begin
        next_oc3 = 1'b1;
        next_pwr_bits[1] = 1'b0;
      end
    end
    // embedded function selective suspend and resume
    if (ctrl[CTRL_FN_SUSPEND] && !fn_susp) begin
      next_fn_susp = 1'b1;
      next_fn_en = 1'b0;
      next_ctrl[CTRL_FN_SUSPEND] = 1'b0;
    end
    if (ctrl[CTRL_FN_RESUME] && fn_susp) begin
      next_fn_susp = 1'b0;
      next_wait_cnt = RESUME_WAIT;
      next_ctrl[CTRL_FN_RESUME] = 1'b0;
    end
    if (wait_cnt != 32'h0000_0000) begin
      next_wait_cnt = wait_cnt - 32'h0000_0001;
      if (wait_cnt == 32'h0000_0001) begin
        next_fn_en = 1'b1;
        next_fn_chg = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_RUN;
      ctrl <= CTRL_RESET;
      pwr_bits <= 2'b00;
      hub_oc <= 1'b0;
      hub_oc_chg <= 1'b0;
      oc2 <= 1'b0;
      oc3 <= 1'b0;
      fn_susp <= 1'b0;
      fn_en <= 1'b1;
      fn_chg <= 1'b0;
      wait_cnt <= 32'h0000_0000;
      port_command_field <= 3'b000;
      port_address_field <= 3'b000;
      port_cmd_stb <= 1'b0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      pwr_bits <= next_pwr_bits;
      hub_oc <= next_hub_oc;
      hub_oc_chg <= next_hub_oc_chg;
      oc2 <= next_oc2;
      oc3 <= next_oc3;
      fn_susp <= next_fn_susp;
      fn_en <= next_fn_en;
      fn_chg <= next_fn_chg;
      wait_cnt <= next_wait_cnt;
      port_command_field <= next_cmd;
      port_address_field <= next_addr;
      port_cmd_stb <= next_cmd_stb;
    end
  end

  // outputs to cpu and hub
  always_comb begin
    sleep_enable_bit = (state == S_SLEEP);
    sleep_mode_bits = (state == S_SLEEP) ? SLEEP_MODE_POWERDOWN : 2'b00;
    sleep_exec = (state == S_SLEEP) && !resume_flag;
    suspend_overcurrent_enable = 8'h00;
    // bit 3 only in individual mode, both lanes need the suspend sense
    suspend_overcurrent_enable[OVC_EN_BIT] = (state == S_SLEEP);
    suspend_overcurrent_enable[OVC3_EN_BIT] = (state == S_SLEEP) &&
      !ctrl[CTRL_GLOBAL_MODE];
    flag_clear = (state == S_WAKE);
    fn_endpoints_en = fn_en;
    // gang off when both control bits clear or gang mode is off
    gang_power_n = ~(ctrl[CTRL_GANG_MODE] && (pwr_bits != 2'b00));
    second_port_power_n = ~(!ctrl[CTRL_GANG_MODE] && pwr_bits[0]);
    third_port_power_n = ~(!ctrl[CTRL_GANG_MODE] && pwr_bits[1]);
  end

  chk_sleep_needs_susp: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == S_RUN) ##1 (state == S_SLEEP) |-> $past(global_suspend_flag))
    else $error("sleep without global suspend");
  chk_wake_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == S_SLEEP) && resume_flag |=> flag_clear ##1 (state == S_RUN))
    else $error("flags not cleared after resume");
  chk_wake_ovc_off: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_clear |=> !suspend_overcurrent_enable[OVC_EN_BIT] && !ctrl[CTRL_SLEEP_REQ])
    else $error("suspend enable left set after resume");
  chk_global_fault_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[CTRL_GLOBAL_MODE] && fall0 |=> hub_oc && hub_oc_chg && pwr_bits == 2'b00)
    else $error("global fault not handled");
  chk_port_fault_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl[CTRL_GLOBAL_MODE] && fall1 |=> oc3 && !pwr_bits[1])
    else $error("port fault not handled");
  chk_gang_both_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[CTRL_GANG_MODE] |-> (gang_power_n == (pwr_bits == 2'b00)))
    else $error("gang output wrong");
  chk_port_power_out: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl[CTRL_GANG_MODE] |-> second_port_power_n == !pwr_bits[0] &&
    third_port_power_n == !pwr_bits[1])
    else $error("port power output wrong");
  chk_cmd_fields: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_stb && wr_strb[0] && wr_addr == OFS_PORTCMD |=>
    port_cmd_stb && port_command_field == $past(wr_data[2:0]))
    else $error("port command not written");
  chk_fn_suspend_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl[CTRL_FN_SUSPEND] && !fn_susp && wait_cnt == 32'h0000_0000 |=>
    fn_susp && !fn_endpoints_en)
    else $error("function endpoints not disabled");
  chk_fn_resume_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(wait_cnt != 32'h0000_0000) |-> !fn_en)
    else $error("function enabled before wait");
  chk_fn_resume_done: assert property (@(posedge aclk) disable iff (!aresetn)
    wait_cnt == 32'h0000_0001 |=> fn_endpoints_en && fn_chg)
    else $error("function not enabled after wait");
  chk_fall_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    fall0 |-> !gpio_d_bit0 && $past(gpio_d_bit0))
    else $error("fault taken without falling edge");
  cov_sleep: cover property (@(posedge aclk) state == S_SLEEP);
  cov_wake: cover property (@(posedge aclk) state == S_WAKE);
  cov_gfault: cover property (@(posedge aclk) fall0 && ctrl[CTRL_GLOBAL_MODE]);
  cov_fn_resume: cover property (@(posedge aclk) wait_cnt == 32'h0000_0001);
  cov_fn_suspend: cover property (@(posedge aclk) fn_susp && !fn_en);
endmodule

// [hub_pm_pkg.sv]
// package for the hub power management controller (firmware-side host)
// assumes a single 20 MHz clock; the hub device is reached through pins
package hub_pm_pkg;
  // clock
  localparam int CLK_HZ = 20_000_000;
  // selective resume settle time of the embedded function
  localparam int RESUME_WAIT_MS = 23;
  localparam int RESUME_WAIT_CYC = RESUME_WAIT_MS * (CLK_HZ / 1000);
  // own register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PORTCMD = 8'h08;
  localparam logic [7:0] OFS_PWR = 8'h0C;
  // ctrl fields
  localparam int CTRL_SLEEP_REQ = 0;
  localparam int CTRL_GLOBAL_MODE = 1;
  localparam int CTRL_GANG_MODE = 2;
  localparam int CTRL_FN_SUSPEND = 3;
  localparam int CTRL_FN_RESUME = 4;
  localparam int CTRL_WAKE_ACK = 5;
  // status fields
  localparam int ST_ASLEEP = 0;
  localparam int ST_HUB_OC = 1;
  localparam int ST_HUB_OC_CHG = 2;
  localparam int ST_OC2 = 3;
  localparam int ST_OC3 = 4;
  localparam int ST_FN_SUSPENDED = 5;
  localparam int ST_FN_EN = 6;
  localparam int ST_FN_SUSP_CHG = 7;
  // suspend overcurrent enable bit position
  localparam int OVC_EN_BIT = 2;
  localparam int OVC3_EN_BIT = 3;
  // cpu control fields, ctrl reset value, bus responses and controller states
  localparam logic [1:0] SLEEP_MODE_POWERDOWN = 2'b10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum {S_RUN, S_SLEEP, S_WAKE} pm_state_t;
endpackage

// [hub_suspend_power_mgmt_tb_top.sv]
// self-checking bench for the hub power management controller
// assumes the hub device model beside it; software side is driven over AXI4-Lite
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, a, e); end end
`define WAITC(c) begin for (int k = 0; k < 300 && !(c); k++) @(negedge aclk); \
  if (!(c)) timeout(); end
module hub_suspend_power_mgmt_tb_top;
  import hub_pm_pkg::*;
  localparam int RESUME_W = 10;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0;
  logic [1:0] bresp, rresp, sleep_mode_bits;
  logic global_suspend_flag, resume_flag, function_wakeup_flag, flag_clear;
  logic sleep_enable_bit, sleep_exec, gpio_d_bit0, gpio_d_bit1;
  logic [7:0] suspend_overcurrent_enable;
  logic gang_power_n, second_port_power_n, third_port_power_n;
  logic [2:0] port_command_field, port_address_field, cmd_seen, addr_seen;
  logic port_cmd_stb, fn_endpoints_en, osc_on, dn_signalling, port_susp_chg;
  logic [5:0] last_port_cmd;
  logic bus_active = 1, host_k = 0, dn_event = 0, ext_irq_one = 0, fault2 = 0, fault3 = 0;
  int miscompares = 0, n_checks = 0, n_stb = 0;

  hub_pm_ctrl #(.RESUME_WAIT(RESUME_W)) dut_u (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .global_suspend_flag,
    .resume_flag, .function_wakeup_flag, .flag_clear, .sleep_enable_bit,
    .sleep_mode_bits, .sleep_exec, .suspend_overcurrent_enable, .gpio_d_bit0,
    .gpio_d_bit1, .gang_power_n, .second_port_power_n, .third_port_power_n,
    .port_command_field, .port_address_field, .port_cmd_stb, .fn_endpoints_en);
  hub_dev_model #(.IDLE_CYC(40)) dev_u (.aclk, .aresetn, .bus_active, .host_k,
    .dn_event, .ext_irq_one, .fault2, .fault3, .sleep_exec, .flag_clear,
    .global_suspend_flag, .resume_flag, .function_wakeup_flag, .osc_on,
    .dn_signalling, .gpio_d_bit0, .gpio_d_bit1, .port_command_field, .port_address_field,
    .port_cmd_stb, .last_port_cmd, .port_susp_chg);

  always #25 aclk = ~aclk;
  // command pulse is one cycle wide, so the falling edge sees it once
  always @(negedge aclk) begin
    if (port_cmd_stb === 1'b1) begin
      n_stb++;
      cmd_seen = port_command_field;
      addr_seen = port_address_field;
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic timeout();
    miscompares++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    give_verdict();
  endtask

  // ready is combinational from registers, so its value at the falling edge holds at the rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) begin
        bready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      d = rdata;
      r = rresp;
      if (rvalid) begin
        @(posedge aclk);
        rready <= 1'b0;
        return;
      end
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    timeout();
  endtask

  task automatic set_reg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    @(negedge aclk);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    `CHK({gang_power_n, second_port_power_n, third_port_power_n}, 3'b111)
    `CHK(fn_endpoints_en, 1'b1)
    axi_rd(OFS_CTRL, d, r);
    `CHK(d, CTRL_RESET)
    axi_rd(8'h40, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h0000_0000)
    axi_wr(8'h40, 32'h0000_0001, r);
    `CHK(r, RESP_SLVERR)
  endtask

  task automatic t_power();
    logic [1:0] pv[5] = '{2'b11, 2'b01, 2'b00, 2'b01, 2'b10};
    logic [1:0] ex[5] = '{2'b00, 2'b00, 2'b11, 2'b01, 2'b10};
    for (int i = 0; i < 5; i++) begin
      if (i == 0) set_reg(OFS_CTRL, 32'h0000_0006);
      if (i == 3) set_reg(OFS_CTRL, 32'h0000_0000);
      set_reg(OFS_PWR, {30'h0, pv[i]});
      if (i < 3) `CHK({2{gang_power_n}}, ex[i])
      else `CHK({second_port_power_n, third_port_power_n}, ex[i])
    end
  endtask

  task automatic t_fault();
    logic [31:0] d;
    logic [1:0] r;
    set_reg(OFS_CTRL, 32'h0000_0006);
    set_reg(OFS_PWR, 32'h0000_0003);
    @(posedge aclk);
    fault2 <= 1'b1;
    `WAITC(gang_power_n)
    axi_rd(OFS_STATUS, d, r);
    `CHK(d[4:1], 4'b0011)
    fault2 <= 1'b0;
    set_reg(OFS_STATUS, 32'h0000_009E);
    set_reg(OFS_CTRL, 32'h0000_0000);
    set_reg(OFS_PWR, 32'h0000_0003);
    @(posedge aclk);
    fault3 <= 1'b1;
    `WAITC(third_port_power_n)
    `CHK(second_port_power_n, 1'b0)
    axi_rd(OFS_STATUS, d, r);
    `CHK(d[4:1], 4'b1000)
    fault3 <= 1'b0;
    set_reg(OFS_STATUS, 32'h0000_009E);
    axi_rd(OFS_STATUS, d, r);
    `CHK(d[4:1], 4'b0000)
  endtask

  task automatic t_portcmd();
    int n;
    logic [1:0] r;
    n = n_stb;
    axi_wr(OFS_PORTCMD, 32'h0000_001C, r);
    repeat (3) @(negedge aclk);
    `CHK(n_stb - n, 1)
    `CHK({addr_seen, cmd_seen}, 6'b011_100)
    `CHK(last_port_cmd, 6'b011_100)
  endtask

  task automatic t_function();
    logic [31:0] d;
    logic [1:0] r;
    int k;
    set_reg(OFS_CTRL, 32'h0000_000E);
    `WAITC(!fn_endpoints_en)
    axi_wr(OFS_CTRL, 32'h0000_0016, r);
    for (k = 0; k < 100 && fn_endpoints_en !== 1'b1; k++) @(negedge aclk);
    `CHK(k >= RESUME_W && k <= RESUME_W + 2, 1'b1)
    axi_rd(OFS_STATUS, d, r);
    `CHK(d[7:5], 3'b110)
  endtask

  // kind 0 host resume, 1 downstream event, 2 function interrupt
  task automatic t_sleep(input logic [31:0] ctrl, input int kind);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(OFS_CTRL, ctrl, r);
    bus_active <= 1'b0;
    `WAITC(sleep_exec)
    @(negedge aclk);
    `CHK(global_suspend_flag & ~dn_signalling & ~osc_on, 1'b1)
    `CHK({sleep_enable_bit, sleep_mode_bits}, {1'b1, SLEEP_MODE_POWERDOWN})
    `CHK(port_susp_chg, 1'b0)
    `CHK(suspend_overcurrent_enable, ctrl[CTRL_GLOBAL_MODE] ? 8'h04 : 8'h0C)
    @(posedge aclk);
    bus_active <= 1'b1;
    host_k <= (kind == 0);
    dn_event <= (kind == 1);
    ext_irq_one <= (kind == 2);
    @(posedge aclk);
    {host_k, dn_event, ext_irq_one} <= 3'b000;
    `WAITC(flag_clear)
    `CHK({resume_flag, function_wakeup_flag}, {1'b1, kind == 2})
    @(negedge aclk);
    `CHK({sleep_exec, suspend_overcurrent_enable[OVC_EN_BIT], osc_on}, 3'b001)
    `CHK(port_susp_chg, 1'b1)
    axi_rd(OFS_CTRL, d, r);
    `CHK(d[CTRL_SLEEP_REQ], 1'b0)
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_reset();
    t_power();
    t_fault();
    t_portcmd();
    t_function();
    t_sleep(32'h0000_0007, 0);
    t_sleep(32'h0000_0007, 1);
    t_sleep(32'h0000_0005, 2);
    give_verdict();
  end
endmodule
